//--- fsg_guard.sv
// Flash section guard: store gating, lock selection, calibration load
// Contract
// - Store acts only when fetched from boot section
// - Separate lock settings for application and boot
// - Table region has its own lock setting
// - Fixed word address map of the sections
// - Table region same size as boot section
// - Boot-issued store may target any mapped section address
// - Boot protection chosen by boot lock bits
// - Fetches from table region are allowed
// - Reset copies calibration values to peripherals
`default_nettype none
module fsg_guard (
  input wire logic mclk,
  input wire logic reset_n,
  input wire fsg_pkg::fsg_store_req_t store_req,
  input wire fsg_pkg::fsg_locks_t locks,
  input wire logic fetch_req,
  input wire logic [13:0] fetch_addr,
  input wire logic [15:0] sig_rdata,
  output logic [1:0] sig_addr,
  output logic flash_wr_en,
  output logic [13:0] flash_wr_addr,
  output logic [15:0] flash_wr_data,
  output logic store_reject,
  output logic fetch_ok,
  output logic cal_wr_en,
  output logic [1:0] cal_wr_idx,
  output logic [15:0] cal_wr_data,
  output logic cal_done
);
  fsg_pkg::fsg_state_t state_q;
  fsg_pkg::fsg_sec_t src_sec;
  fsg_pkg::fsg_sec_t dst_sec;
  logic [1:0] dst_lock;
  logic store_ok;
  localparam logic [13:0] tbl_span = fsg_pkg::TBL_END - fsg_pkg::TBL_START;
  localparam logic [13:0] boot_span = fsg_pkg::BOOT_END - fsg_pkg::BOOT_START;

  function automatic fsg_pkg::fsg_sec_t sec_of(input logic [13:0] a);
    if (a <= fsg_pkg::APP_END) begin
      sec_of = fsg_pkg::FSG_SEC_APP;
    end else if (a >= fsg_pkg::TBL_START && a <= fsg_pkg::TBL_END) begin
      sec_of = fsg_pkg::FSG_SEC_TBL;
    end else if (a >= fsg_pkg::BOOT_START && a <= fsg_pkg::BOOT_END) begin
      sec_of = fsg_pkg::FSG_SEC_BOOT;
    end else begin
      sec_of = fsg_pkg::FSG_SEC_NONE;
    end
  endfunction

  // Table and boot spans must match; caught at elaboration
  if (tbl_span != boot_span) begin : g_sz
    $error("table and boot section sizes differ");
  end

  always_comb begin
    src_sec = sec_of(store_req.fetch_addr);
    dst_sec = sec_of(store_req.target_addr);
    case (dst_sec)
      fsg_pkg::FSG_SEC_APP: dst_lock = locks.app;
      fsg_pkg::FSG_SEC_TBL: dst_lock = locks.tbl;
      fsg_pkg::FSG_SEC_BOOT: dst_lock = locks.boot;
      default: dst_lock = 2'h1;
    endcase
    // Any mapped section is a legal target from boot, including boot itself
    store_ok = store_req.valid && (src_sec == fsg_pkg::FSG_SEC_BOOT)
      && (dst_sec != fsg_pkg::FSG_SEC_NONE) && !dst_lock[fsg_pkg::LOCK_WR_BIT];
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flash_wr_en <= 1'b0;
      flash_wr_addr <= 14'h0000;
      flash_wr_data <= 16'h0000;
      store_reject <= 1'b0;
    end else begin
      flash_wr_en <= store_ok && state_q == fsg_pkg::FSG_ST_RUN;
      flash_wr_addr <= store_req.target_addr;
      flash_wr_data <= store_req.data;
      store_reject <= store_req.valid && !(store_ok && state_q == fsg_pkg::FSG_ST_RUN);
    end
  end

  // Table region is ordinary code space for fetches
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_ok <= 1'b0;
    end else begin
      fetch_ok <= fetch_req && sec_of(fetch_addr) != fsg_pkg::FSG_SEC_NONE;
    end
  end

  // Signature row read has one cycle latency; WAIT state covers it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= fsg_pkg::FSG_ST_LOAD;
      sig_addr <= 2'h0;
      cal_wr_en <= 1'b0;
      cal_wr_idx <= 2'h0;
      cal_wr_data <= 16'h0000;
      cal_done <= 1'b0;
    end else begin
      cal_wr_en <= 1'b0;
      case (state_q)
        fsg_pkg::FSG_ST_LOAD: begin
          state_q <= fsg_pkg::FSG_ST_WAIT;
        end
        fsg_pkg::FSG_ST_WAIT: begin
          cal_wr_en <= 1'b1;
          cal_wr_idx <= sig_addr;
          cal_wr_data <= sig_rdata;
          if (sig_addr == fsg_pkg::CAL_IDX_LAST) begin
            state_q <= fsg_pkg::FSG_ST_RUN;
            cal_done <= 1'b1;
          end else begin
            sig_addr <= sig_addr + 2'h1;
            state_q <= fsg_pkg::FSG_ST_LOAD;
          end
        end
        fsg_pkg::FSG_ST_RUN: begin
          cal_done <= 1'b1;
        end
        default: state_q <= fsg_pkg::FSG_ST_LOAD;
      endcase
    end
  end

  property p_src_boot;
    @(posedge mclk) disable iff (!reset_n)
      flash_wr_en |-> sec_of($past(store_req.fetch_addr)) == fsg_pkg::FSG_SEC_BOOT;
  endproperty
  a_src_boot: assert property (p_src_boot) else $error("store from outside boot");

  property p_app_lock;
    @(posedge mclk) disable iff (!reset_n)
      flash_wr_en && sec_of(flash_wr_addr) == fsg_pkg::FSG_SEC_APP
        |-> !$past(locks.app[fsg_pkg::LOCK_WR_BIT]);
  endproperty
  a_app_lock: assert property (p_app_lock) else $error("app lock bypassed");

  property p_tbl_lock;
    @(posedge mclk) disable iff (!reset_n)
      flash_wr_en && sec_of(flash_wr_addr) == fsg_pkg::FSG_SEC_TBL
        |-> !$past(locks.tbl[fsg_pkg::LOCK_WR_BIT]);
  endproperty
  a_tbl_lock: assert property (p_tbl_lock) else $error("table lock bypassed");

  property p_boot_lock;
    @(posedge mclk) disable iff (!reset_n)
      flash_wr_en && sec_of(flash_wr_addr) == fsg_pkg::FSG_SEC_BOOT
        |-> !$past(locks.boot[fsg_pkg::LOCK_WR_BIT]);
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("boot lock bypassed");

  property p_boot_any;
    @(posedge mclk) disable iff (!reset_n)
      store_ok && state_q == fsg_pkg::FSG_ST_RUN
        |=> flash_wr_en && flash_wr_addr == $past(store_req.target_addr);
  endproperty
  a_boot_any: assert property (p_boot_any) else $error("legal store dropped");

  property p_reject;
    @(posedge mclk) disable iff (!reset_n)
      store_req.valid && !store_ok |=> store_reject && !flash_wr_en;
  endproperty
  a_reject: assert property (p_reject) else $error("locked store not ignored");

  property p_fetch_tbl;
    @(posedge mclk) disable iff (!reset_n)
      fetch_req && sec_of(fetch_addr) == fsg_pkg::FSG_SEC_TBL |=> fetch_ok;
  endproperty
  a_fetch_tbl: assert property (p_fetch_tbl) else $error("table fetch refused");

  sequence s_cal_step;
    state_q == fsg_pkg::FSG_ST_WAIT ##1 cal_wr_en;
  endsequence
  property p_cal_load;
    @(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> ##[0:8] cal_done;
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibration load too slow");

  property p_cal_step;
    @(posedge mclk) disable iff (!reset_n)
      s_cal_step |-> cal_wr_data == $past(sig_rdata);
  endproperty
  a_cal_step: assert property (p_cal_step) else $error("calibration data wrong");

  // No store may reach the flash while calibration is still loading
  property p_cal_gate;
    @(posedge mclk) disable iff (!reset_n)
      state_q != fsg_pkg::FSG_ST_RUN |=> !flash_wr_en;
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("store during calibration");

  property p_cal_idx;
    @(posedge mclk) disable iff (!reset_n)
      cal_wr_en |-> cal_wr_idx == $past(sig_addr);
  endproperty
  a_cal_idx: assert property (p_cal_idx) else $error("calibration index wrong");

  // After the last word the rest is left to software
  property p_cal_hold;
    @(posedge mclk) disable iff (!reset_n)
      cal_done |=> cal_done && !cal_wr_en;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration load went on");

  property p_fetch_none;
    @(posedge mclk) disable iff (!reset_n)
      fetch_req && sec_of(fetch_addr) == fsg_pkg::FSG_SEC_NONE |=> !fetch_ok;
  endproperty
  a_fetch_none: assert property (p_fetch_none) else $error("unmapped fetch accepted");

  property p_wr_data;
    @(posedge mclk) disable iff (!reset_n)
      flash_wr_en |-> flash_wr_data == $past(store_req.data);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("store data wrong");

  property p_one_answer;
    @(posedge mclk) disable iff (!reset_n)
      flash_wr_en |-> !store_reject;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("store both taken and refused");

  property p_reject_cause;
    @(posedge mclk) disable iff (!reset_n)
      store_reject |-> $past(store_req.valid);
  endproperty
  a_reject_cause: assert property (p_reject_cause) else $error("refusal without store");
endmodule // fsg_guard
`default_nettype wire

//--- fsg_pkg.sv
// Package for the flash section access guard
`default_nettype none
package fsg_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam logic [13:0] APP_END = 14'h17FF;
  localparam logic [13:0] TBL_START = 14'h1800;
  localparam logic [13:0] TBL_END = 14'h1FFF;
  localparam logic [13:0] BOOT_START = 14'h2000;
  localparam logic [13:0] BOOT_END = 14'h27FF;
  localparam int CAL_N = 4;
  localparam logic [1:0] CAL_IDX_LAST = 2'h3;
  // Lock levels: bit0 set forbids store into the section
  localparam int LOCK_W = 2;
  localparam int LOCK_WR_BIT = 0;
  localparam logic [1:0] LOCK_RESET = 2'h3;

  typedef enum logic [1:0] {
    FSG_SEC_APP = 2'h0,
    FSG_SEC_TBL = 2'h1,
    FSG_SEC_BOOT = 2'h2,
    FSG_SEC_NONE = 2'h3
  } fsg_sec_t;

  typedef struct packed {
    logic valid;
    logic [13:0] fetch_addr;
    logic [13:0] target_addr;
    logic [15:0] data;
  } fsg_store_req_t;

  typedef struct packed {
    logic [1:0] app;
    logic [1:0] tbl;
    logic [1:0] boot;
  } fsg_locks_t;

  typedef enum logic [2:0] {
    FSG_ST_LOAD = 3'b001,
    FSG_ST_WAIT = 3'b010,
    FSG_ST_RUN = 3'b100
  } fsg_state_t;
endpackage
`default_nettype wire

//--- fsg_core_model.sv
// Signature row and calibration sink seen from the guard
`default_nettype none
module fsg_core_model (
  input wire logic mclk,
  input wire logic [1:0] sig_addr,
  output logic [15:0] sig_rdata,
  input wire logic cal_wr_en,
  input wire logic [1:0] cal_wr_idx,
  input wire logic [15:0] cal_wr_data,
  output logic [63:0] cal_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // Row holds only the auto-loaded words; the others are software's job
  // Row answers one cycle after the index
  always @(posedge mclk) begin
    sig_rdata <= 16'hA500 | {14'h0, sig_addr};
  end
  // Keeps what the peripherals were handed at reset
  always @(posedge mclk) begin
    if (cal_wr_en) cal_seen[16 * cal_wr_idx +: 16] <= cal_wr_data;
  end
endmodule // fsg_core_model
`default_nettype wire

//--- flash_section_access_guard_tb.sv
// Self-checking bench for the flash section guard
`default_nettype none
module flash_section_access_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, fetch_req, flash_wr_en, store_reject, fetch_ok, cal_wr_en, cal_done;
  logic [13:0] fetch_addr, flash_wr_addr;
  logic [15:0] sig_rdata, flash_wr_data, cal_wr_data;
  logic [1:0] sig_addr, cal_wr_idx;
  logic [63:0] cal_seen;
  fsg_pkg::fsg_store_req_t store_req;
  fsg_pkg::fsg_locks_t locks;
  int bad_count, tests_run;
  fsg_guard i_dut (.mclk(mclk), .reset_n(reset_n), .store_req(store_req), .locks(locks),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .sig_rdata(sig_rdata),
    .sig_addr(sig_addr), .flash_wr_en(flash_wr_en), .flash_wr_addr(flash_wr_addr),
    .flash_wr_data(flash_wr_data), .store_reject(store_reject), .fetch_ok(fetch_ok),
    .cal_wr_en(cal_wr_en), .cal_wr_idx(cal_wr_idx), .cal_wr_data(cal_wr_data),
    .cal_done(cal_done));
  fsg_core_model i_core (.mclk(mclk), .sig_addr(sig_addr), .sig_rdata(sig_rdata),
    .cal_wr_en(cal_wr_en), .cal_wr_idx(cal_wr_idx), .cal_wr_data(cal_wr_data),
    .cal_seen(cal_seen));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Data tied to target so a wrong word shows
  task automatic store(input logic [13:0] fa, input logic [13:0] ta, input logic ok);
    @(negedge mclk);
    store_req = '{1'b1, fa, ta, 16'h5A00 ^ {2'h0, ta}};
    @(negedge mclk);
    store_req.valid = 1'b0;
    chk("flash_wr_en", {15'h0, flash_wr_en}, {15'h0, ok});
    chk("store_reject", {15'h0, store_reject}, {15'h0, !ok});
    if (ok) chk("flash_wr_addr", {2'h0, flash_wr_addr}, {2'h0, ta});
    if (ok) chk("flash_wr_data", flash_wr_data, 16'h5A00 ^ {2'h0, ta});
  endtask
  task automatic fetch(input logic [13:0] a, input logic ok);
    @(negedge mclk);
    fetch_req = 1'b1;
    fetch_addr = a;
    @(negedge mclk);
    fetch_req = 1'b0;
    chk("fetch_ok", {15'h0, fetch_ok}, {15'h0, ok});
  endtask
  task automatic t_cal;
    // Boot store while loading must still be refused
    store(14'h2000, 14'h0100, 1'b0);
    repeat (9) @(posedge mclk);
    @(negedge mclk);
    chk("cal_done", {15'h0, cal_done}, 16'h1);
    chk("cal_wr_en", {15'h0, cal_wr_en}, 16'h0);
    for (int i = 0; i < 4; i++) chk("cal", cal_seen[16 * i +: 16], 16'hA500 | 16'(i));
  endtask
  task automatic t_gate;
    store(14'h2000, 14'h0100, 1'b1);
    store(14'h17FF, 14'h0100, 1'b0);
    store(14'h1800, 14'h0100, 1'b0);
    store(14'h27FF, 14'h2000, 1'b1);
    store(14'h2800, 14'h0100, 1'b0);
    store(14'h2000, 14'h2800, 1'b0);
  endtask
  task automatic t_locks;
    locks = '{app: 2'h1, tbl: 2'h0, boot: 2'h0};
    store(14'h2000, 14'h17FF, 1'b0);
    store(14'h2000, 14'h1800, 1'b1);
    locks = '{app: 2'h2, tbl: 2'h1, boot: 2'h0};
    store(14'h2000, 14'h0000, 1'b1);
    store(14'h2000, 14'h1FFF, 1'b0);
    store(14'h2000, 14'h2000, 1'b1);
    locks = '{app: 2'h0, tbl: 2'h0, boot: 2'h1};
    store(14'h2000, 14'h27FF, 1'b0);
    store(14'h2000, 14'h1FFF, 1'b1);
  endtask
  task automatic t_fetch;
    fetch(14'h1800, 1'b1);
    fetch(14'h27FF, 1'b1);
    fetch(14'h2800, 1'b0);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // About 55 cycles expected, so a hang is cut well past that
  initial begin
    #5000;
    bad_count++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    fetch_req = 1'b0;
    fetch_addr = 14'h0;
    store_req = '0;
    locks = '0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    t_cal();
    t_gate();
    t_locks();
    t_fetch();
    end_of_test();
  end
endmodule // flash_section_access_guard_tb
`default_nettype wire
